//--- uspc_regs.sv
// Purpose: status, latch, debug, scratch and kit registers of a usb transceiver
// Assumes: single-cycle register port from the link-side interface logic
// Notes:   read data is registered; rd_valid marks the return cycle
`timescale 1ns/100ps

// Operation
// - status register shows live source levels
// - id ground frozen until pull-up settled
// - host disconnect forced low in low power
// - host disconnect resets low, then follows its source outside low power
// - unmasked source transition sets latch bit
// - latch read clears all latch bits
// - low-power entry clears latch
// - serial or kit mode entry clears latch
// - coinciding event goes in read data
// - debug bits mirror single-ended receivers
// - line code encodes bus state
// - scratch byte resets zero, no side effect
// - set alias sets base bits
// - clear alias clears base bits
// - kit controls active only in kit mode
// - rx route copies d+ to data1
// - tx route copies data0 to d-
// - id drive low grounds id pin
// - id float enables raise kit events
// - kit status bit0 shows id floating
// - rise/fall enables mask transitions
module uspc_regs #(
  parameter int SETTLE_CYCLES = uspc_pkg::ID_SETTLE_CYCLES
) (
  input  wire logic       core_clk,       // core clock, 200 MHz
  input  wire logic       rst_n,          // async reset, active low
  input  wire logic       reg_wr,         // write strobe, one cycle
  input  wire logic       reg_rd,         // read strobe, one cycle
  input  wire logic [7:0] reg_addr,       // register byte address
  input  wire logic [7:0] reg_wdata,      // write data
  output logic      [7:0] reg_rdata,      // read data, registered
  output logic            reg_rd_valid,   // read data valid pulse
  input  wire logic [4:0] src_levels_pin, // id gnd, sess end, sess valid, vbus valid, host disc
  input  wire logic [4:0] rise_en,        // rising transition enables
  input  wire logic [4:0] fall_en,        // falling transition enables
  input  wire logic       id_pull_up_on,  // id pull-up control
  input  wire logic       kit_mode_on,    // kit mode control
  input  wire logic       serial_mode_on, // serial mode active
  input  wire logic       low_power_on,   // low-power mode active
  input  wire logic       clock_suspend_ctl, // clock suspend control, no effect on clears
  input  wire logic [1:0] line_pin,       // single-ended receivers: [0] d+, [1] d-
  input  wire logic       id_floating_pin, // id pin floating detector
  input  wire logic       dp_rx_pin,      // receive data arriving on d+
  input  wire logic       data0_tx,       // transmit data from data bus bit 0
  output logic            data1_rx_out,   // routed receive data onto data bus bit 1
  output logic            data1_rx_oe,    // drive enable for data bus bit 1
  output logic            dm_tx_out,      // routed transmit data onto d-
  output logic            dm_tx_oe,       // drive enable for d-
  output logic            id_drive_low,   // pull id pin to ground
  output logic            kit_event       // id float event pulse
);
  // pin-side inputs pass two flops
  logic [4:0] src_sync;
  logic [1:0] line_level_code;
  logic       id_floating;
  logic       dp_rx_sync;

  uspc_sync2 #(.W(9)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d_async  ({src_levels_pin, line_pin, id_floating_pin, dp_rx_pin}),
    .q_sync   ({src_sync, line_level_code, id_floating, dp_rx_sync})
  );

  logic id_settled;

  uspc_settle_timer #(.CYCLES(SETTLE_CYCLES)) u_settle (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pull_on  (id_pull_up_on),
    .settled  (id_settled)
  );

  function automatic logic [7:0] alias_apply(input logic [7:0] base, input logic [7:0] wdata,
                                             input logic [1:0] kind, input logic [7:0] mask);
    logic [7:0] v;
    v = base;
    case (kind)
      2'h0:    v = wdata;
      2'h1:    v = base | wdata;
      2'h2:    v = base & ~wdata;
      default: v = base;
    endcase
    return v & mask;
  endfunction : alias_apply

  // one decode for each base register and its two aliases
  function automatic logic [1:0] alias_kind(input logic [7:0] addr, input logic [7:0] base,
                                            input logic [7:0] set_a, input logic [7:0] clr_a);
    logic [1:0] k;
    k = 2'h3;
    if (addr == base) begin
      k = 2'h0;
    end else if (addr == set_a) begin
      k = 2'h1;
    end else if (addr == clr_a) begin
      k = 2'h2;
    end
    return k;
  endfunction : alias_kind

  // source level register with frozen id ground and forced host disconnect
  logic [4:0] src_level_reg;
  logic       src_primed_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_level_reg  <= 5'h00;
      src_primed_reg <= 1'b0;
    end else begin
      src_primed_reg <= 1'b1;
      src_level_reg[3:1] <= src_sync[3:1];
      if (id_settled && id_pull_up_on) begin
        src_level_reg[uspc_pkg::BIT_ID_GND] <= src_sync[uspc_pkg::BIT_ID_GND];
      end
      if (low_power_on) begin
        src_level_reg[uspc_pkg::BIT_HOSTDIS] <= 1'b0;
      end else begin
        src_level_reg[uspc_pkg::BIT_HOSTDIS] <= src_sync[uspc_pkg::BIT_HOSTDIS];
      end
    end
  end

  // transition detect against the previous filtered level
  logic [4:0] src_prev_reg;
  logic [4:0] src_event;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_reg <= 5'h00;
    end else begin
      src_prev_reg <= src_level_reg;
    end
  end

  always_comb begin
    src_event = ((src_level_reg & ~src_prev_reg & rise_en) |
                 (~src_level_reg & src_prev_reg & fall_en)) & {5{src_primed_reg}};
  end

  // mode entry edges for latch clearing
  logic serial_prev_reg;
  logic kit_prev_reg;
  logic lp_prev_reg;
  logic mode_entry;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_prev_reg <= 1'b0;
      kit_prev_reg    <= 1'b0;
      lp_prev_reg     <= 1'b0;
    end else begin
      serial_prev_reg <= serial_mode_on;
      kit_prev_reg    <= kit_mode_on;
      lp_prev_reg     <= low_power_on;
    end
  end

  // clock_suspend_ctl deliberately not a term here
  assign mode_entry = (low_power_on & ~lp_prev_reg) |
                      (serial_mode_on & ~serial_prev_reg) | (kit_mode_on & ~kit_prev_reg);

  // address decode
  logic rd_latch;
  logic wr_scr;
  logic wr_kit;
  logic wr_dly;
  logic wr_ien;
  logic [1:0] scr_kind;
  logic [1:0] kit_kind;
  logic [1:0] ien_kind;

  always_comb begin
    rd_latch = reg_rd && (reg_addr == uspc_pkg::ADDR_EVT_LATCH);
    wr_dly   = reg_wr && (reg_addr == uspc_pkg::ADDR_KIT_DELAY);
    scr_kind = reg_wr ? alias_kind(reg_addr, uspc_pkg::ADDR_SCRATCH, uspc_pkg::ADDR_SCRATCH_SET,
                                   uspc_pkg::ADDR_SCRATCH_CLR) : 2'h3;
    kit_kind = reg_wr ? alias_kind(reg_addr, uspc_pkg::ADDR_KIT_CTL, uspc_pkg::ADDR_KIT_CTL_SET,
                                   uspc_pkg::ADDR_KIT_CTL_CLR) : 2'h3;
    ien_kind = reg_wr ? alias_kind(reg_addr, uspc_pkg::ADDR_KIT_IEN, uspc_pkg::ADDR_KIT_IEN_SET,
                                   uspc_pkg::ADDR_KIT_IEN_CLR) : 2'h3;
    wr_scr   = (scr_kind != 2'h3);
    wr_kit   = (kit_kind != 2'h3);
    wr_ien   = (ien_kind != 2'h3);
  end

  // event latch: read clears, coinciding event reported not stored
  logic [4:0] latch_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= 5'h00;
    end else if (rd_latch || mode_entry) begin
      latch_reg <= 5'h00;
    end else begin
      latch_reg <= latch_reg | src_event;
    end
  end

  // writable storage
  logic [7:0] scratch_reg;
  logic [7:0] kit_ctl_reg;
  logic [7:0] kit_dly_reg;
  logic [7:0] kit_ien_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scratch_reg <= uspc_pkg::RST_SCRATCH;
    end else if (wr_scr) begin
      scratch_reg <= alias_apply(scratch_reg, reg_wdata, scr_kind, 8'hFF);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      kit_ctl_reg <= uspc_pkg::RST_KIT_CTL;
    end else if (wr_kit) begin
      kit_ctl_reg <= alias_apply(kit_ctl_reg, reg_wdata, kit_kind, uspc_pkg::MASK_KIT_CTL);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      kit_dly_reg <= uspc_pkg::RST_KIT_DELAY;
    end else if (wr_dly) begin
      kit_dly_reg <= reg_wdata & uspc_pkg::MASK_KIT_DELAY;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      kit_ien_reg <= uspc_pkg::RST_KIT_IEN;
    end else if (wr_ien) begin
      kit_ien_reg <= alias_apply(kit_ien_reg, reg_wdata, ien_kind, uspc_pkg::MASK_KIT_IEN);
    end
  end

  // read mux, registered
  logic [7:0] rd_mux;

  always_comb begin
    case (reg_addr)
      uspc_pkg::ADDR_SRC_LEVEL:   rd_mux = {3'h0, src_level_reg};
      uspc_pkg::ADDR_EVT_LATCH:   rd_mux = {3'h0, latch_reg | src_event};
      uspc_pkg::ADDR_LINE_DEBUG:  rd_mux = {6'h00, line_level_code};
      uspc_pkg::ADDR_SCRATCH,
      uspc_pkg::ADDR_SCRATCH_SET,
      uspc_pkg::ADDR_SCRATCH_CLR: rd_mux = scratch_reg;
      uspc_pkg::ADDR_KIT_CTL,
      uspc_pkg::ADDR_KIT_CTL_SET,
      uspc_pkg::ADDR_KIT_CTL_CLR: rd_mux = kit_ctl_reg;
      uspc_pkg::ADDR_KIT_DELAY:   rd_mux = kit_dly_reg;
      uspc_pkg::ADDR_KIT_IEN,
      uspc_pkg::ADDR_KIT_IEN_SET,
      uspc_pkg::ADDR_KIT_IEN_CLR: rd_mux = kit_ien_reg;
      uspc_pkg::ADDR_KIT_STS:     rd_mux = {7'h00, id_floating};
      default:                    rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata    <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // kit routing outputs; controls inert outside kit mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data1_rx_oe  <= 1'b0;
      dm_tx_oe     <= 1'b0;
      id_drive_low <= 1'b0;
      data1_rx_out <= 1'b0;
      dm_tx_out    <= 1'b0;
    end else begin
      data1_rx_oe  <= kit_mode_on & kit_ctl_reg[uspc_pkg::BIT_RX_ROUTE];
      dm_tx_oe     <= kit_mode_on & kit_ctl_reg[uspc_pkg::BIT_TX_ROUTE];
      id_drive_low <= kit_mode_on & kit_ctl_reg[uspc_pkg::BIT_ID_DRIVE];
      data1_rx_out <= dp_rx_sync;
      dm_tx_out    <= data0_tx;
    end
  end

  // id float transitions, only meaningful once pull-up settled
  logic float_prev_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      float_prev_reg <= 1'b0;
      kit_event      <= 1'b0;
    end else begin
      float_prev_reg <= id_floating;
      kit_event      <= id_settled & src_primed_reg &
        ((kit_ien_reg[uspc_pkg::BIT_UNFLOAT_IRQ] & float_prev_reg & ~id_floating) |
         (kit_ien_reg[uspc_pkg::BIT_FLOAT_IRQ] & ~float_prev_reg & id_floating));
    end
  end

  AST_LATCH_READ_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_latch |=> latch_reg == 5'h00) else $error("latch not cleared by read");

  AST_EVENT_SETS_LATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
    (src_event != 5'h00 && !rd_latch && !mode_entry) |=> ((latch_reg & $past(src_event)) == $past(src_event)))
    else $error("event lost from latch");

  AST_COINCIDE_IN_DATA: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_latch |=> reg_rd_valid && ((reg_rdata[4:0] & $past(src_event)) == $past(src_event)))
    else $error("coinciding event missing in read data");

  AST_MODE_ENTRY_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode_entry |=> latch_reg == 5'h00) else $error("mode entry did not clear latch");

  sequence pull_off_run_s;
    !id_pull_up_on ##1 !id_pull_up_on;
  endsequence

  AST_ID_FROZEN: assert property (@(posedge core_clk) disable iff (!rst_n)
    pull_off_run_s |=> $stable(src_level_reg[uspc_pkg::BIT_ID_GND]))
    else $error("id ground moved without pull-up");

  AST_HOSTDIS_LOWPOWER: assert property (@(posedge core_clk) disable iff (!rst_n)
    low_power_on |=> !src_level_reg[uspc_pkg::BIT_HOSTDIS]) else $error("host disconnect high in low power");

  AST_KIT_GATED: assert property (@(posedge core_clk) disable iff (!rst_n)
    !kit_mode_on |=> !data1_rx_oe && !dm_tx_oe && !id_drive_low) else $error("kit control active outside kit mode");

  AST_STATUS_UPPER_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == uspc_pkg::ADDR_SRC_LEVEL |=> reg_rdata[7:5] == 3'h0 && reg_rdata[4:0] == $past(src_level_reg))
    else $error("status read wrong");

  AST_DEBUG_MIRROR: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == uspc_pkg::ADDR_LINE_DEBUG |=> reg_rdata == {6'h00, $past(line_level_code)})
    else $error("debug read wrong");

  AST_SET_ALIAS: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == uspc_pkg::ADDR_SCRATCH_SET |=> scratch_reg == ($past(scratch_reg) | $past(reg_wdata)))
    else $error("set alias wrong");

  AST_CLR_ALIAS: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == uspc_pkg::ADDR_SCRATCH_CLR |=> scratch_reg == ($past(scratch_reg) & ~$past(reg_wdata)))
    else $error("clear alias wrong");

  AST_KIT_STATUS: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == uspc_pkg::ADDR_KIT_STS |=> reg_rdata == {7'h00, $past(id_floating)})
    else $error("kit status read wrong");
endmodule : uspc_regs

//--- uspc_pkg.sv
// Purpose: shared constants for the transceiver status and kit register bank
// Assumes: 8-bit registers at their printed byte offsets
// Notes:   timing counts derive from the 200 MHz core clock
package uspc_pkg;
  localparam logic [7:0] ADDR_SRC_LEVEL   = 8'h13;
  localparam logic [7:0] ADDR_EVT_LATCH   = 8'h14;
  localparam logic [7:0] ADDR_LINE_DEBUG  = 8'h15;
  localparam logic [7:0] ADDR_SCRATCH     = 8'h16;
  localparam logic [7:0] ADDR_SCRATCH_SET = 8'h17;
  localparam logic [7:0] ADDR_SCRATCH_CLR = 8'h18;
  localparam logic [7:0] ADDR_KIT_CTL     = 8'h19;
  localparam logic [7:0] ADDR_KIT_CTL_SET = 8'h1A;
  localparam logic [7:0] ADDR_KIT_CTL_CLR = 8'h1B;
  localparam logic [7:0] ADDR_KIT_DELAY   = 8'h1C;
  localparam logic [7:0] ADDR_KIT_IEN     = 8'h1D;
  localparam logic [7:0] ADDR_KIT_IEN_SET = 8'h1E;
  localparam logic [7:0] ADDR_KIT_IEN_CLR = 8'h1F;
  localparam logic [7:0] ADDR_KIT_STS     = 8'h20;

  localparam logic [7:0] RST_SCRATCH   = 8'h00;
  localparam logic [7:0] RST_KIT_CTL   = 8'h00;
  localparam logic [7:0] RST_KIT_DELAY = 8'h52;
  localparam logic [7:0] RST_KIT_IEN   = 8'h00;

  localparam logic [7:0] MASK_KIT_CTL   = 8'h7F;
  localparam logic [7:0] MASK_KIT_DELAY = 8'h7F;
  localparam logic [7:0] MASK_KIT_IEN   = 8'h1F;

  localparam int SRC_W       = 5;
  localparam int BIT_ID_GND  = 4;
  localparam int BIT_HOSTDIS = 0;
  localparam int BIT_RX_ROUTE = 3;
  localparam int BIT_TX_ROUTE = 2;
  localparam int BIT_ID_DRIVE = 1;
  localparam int BIT_UNFLOAT_IRQ = 1;
  localparam int BIT_FLOAT_IRQ   = 0;

  localparam int CLK_MHZ         = 200;
  localparam int ID_SETTLE_MS    = 50;
  localparam int ID_SETTLE_CYCLES = ID_SETTLE_MS * 1000 * CLK_MHZ;
endpackage : uspc_pkg

//--- uspc_sync2.sv
// Purpose: two-flop synchroniser for a bus of pin levels
// Assumes: inputs are quasi-static relative to core_clk
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
module uspc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         core_clk, // core clock
  input  wire logic         rst_n,    // async reset, active low
  input  wire logic [W-1:0] d_async,  // raw pin levels
  output logic      [W-1:0] q_sync    // synchronised levels
);
  logic [W-1:0] stage1_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      q_sync     <= '0;
    end else begin
      stage1_reg <= d_async;
      q_sync     <= stage1_reg;
    end
  end
endmodule : uspc_sync2

//--- uspc_settle_timer.sv
// Purpose: hold-off timer for the id ground sample after pull-up enable
// Assumes: pull_on comes from core_clk logic
// Notes:   settled stays low while pull-up off and for CYCLES+1 cycles after it rises
`timescale 1ns/100ps
module uspc_settle_timer #(
  parameter int CYCLES = uspc_pkg::ID_SETTLE_CYCLES
) (
  input  wire logic core_clk, // core clock
  input  wire logic rst_n,    // async reset, active low
  input  wire logic pull_on,  // id pull-up enabled
  output logic      settled   // sampling allowed
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] count_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (!pull_on) begin
      count_reg <= '0;
    end else if (count_reg != CW'(CYCLES)) begin
      count_reg <= count_reg + CW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      settled <= 1'b0;
    end else begin
      settled <= pull_on && (count_reg == CW'(CYCLES));
    end
  end
endmodule : uspc_settle_timer

//--- uspc_link_model.sv
// Purpose: link-side register master for the status and kit bank
// Assumes: one-cycle strobes launched at the falling edge
// Notes:   read data is taken in the cycle the valid pulse shows
`timescale 1ns/100ps
module uspc_link_model (
  input  wire logic       core_clk,    // core clock
  output logic            reg_wr,      // write strobe
  output logic            reg_rd,      // read strobe
  output logic      [7:0] reg_addr,    // byte address
  output logic      [7:0] reg_wdata,   // write data
  input  wire logic [7:0] reg_rdata,   // read data
  input  wire logic       reg_rd_valid // read data valid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    // released data lines show the inverse, not the old value
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    // bounded wait, a lost pulse must not hang the bench
    while (reg_rd_valid !== 1'b1 && n < 4) begin
      @(negedge core_clk);
      n++;
    end
    d = (reg_rd_valid === 1'b1) ? reg_rdata : 8'hXX;
  endtask : rd
endmodule : uspc_link_model

//--- testbench.sv
// Purpose: self-checking bench for the status and kit register bank
// Assumes: settle count shortened to 20 cycles
// Notes:   inputs change at the falling edge only
`timescale 1ns/100ps
module testbench;
  logic       core_clk;
  logic       rst_n;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_rd_valid;
  logic [4:0] src;
  logic [4:0] rise_en;
  logic [4:0] fall_en;
  logic       pull_on;
  logic       kit_on;
  logic       ser_on;
  logic       lp_on;
  logic       susp;
  logic [1:0] line_pin;
  logic       id_flt;
  logic       dp_rx;
  logic       d0_tx;
  logic       d1_out;
  logic       d1_oe;
  logic       dm_out;
  logic       dm_oe;
  logic       id_low;
  logic       kit_event;
  int         bad_count;
  int         cmp_count;

  uspc_regs #(.SETTLE_CYCLES(20)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .src_levels_pin(src), .rise_en(rise_en),
    .fall_en(fall_en), .id_pull_up_on(pull_on), .kit_mode_on(kit_on),
    .serial_mode_on(ser_on), .low_power_on(lp_on), .clock_suspend_ctl(susp),
    .line_pin(line_pin), .id_floating_pin(id_flt), .dp_rx_pin(dp_rx),
    .data0_tx(d0_tx), .data1_rx_out(d1_out), .data1_rx_oe(d1_oe),
    .dm_tx_out(dm_out), .dm_tx_oe(dm_oe), .id_drive_low(id_low),
    .kit_event(kit_event));

  uspc_link_model link (
    .core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

  always #2.5 core_clk = ~core_clk;

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    link.rd(a, d);
    chk($sformatf("reg_%h", a), exp, d);
  endtask : rchk

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic pulses(output logic [7:0] n);
    n = 8'h00;
    repeat (10) begin
      @(negedge core_clk);
      if (kit_event === 1'b1) n++;
    end
  endtask : pulses

  task automatic t_reset_vals;
    rchk(uspc_pkg::ADDR_SCRATCH, 8'h00);
    rchk(uspc_pkg::ADDR_KIT_CTL, 8'h00);
    rchk(uspc_pkg::ADDR_KIT_DELAY, 8'h52);
    rchk(uspc_pkg::ADDR_KIT_IEN, 8'h00);
    rchk(uspc_pkg::ADDR_EVT_LATCH, 8'h00);
    link.wr(8'h21, 8'hFF);
    rchk(8'h21, 8'h00);
    $display("test reset_vals done");
  endtask : t_reset_vals

  task automatic t_aliases;
    link.wr(uspc_pkg::ADDR_SCRATCH, 8'hA5);
    rchk(uspc_pkg::ADDR_SCRATCH, 8'hA5);
    link.wr(uspc_pkg::ADDR_SCRATCH_SET, 8'h0A);
    rchk(uspc_pkg::ADDR_SCRATCH_SET, 8'hAF);
    link.wr(uspc_pkg::ADDR_SCRATCH_CLR, 8'h21);
    rchk(uspc_pkg::ADDR_SCRATCH_CLR, 8'h8E);
    link.wr(uspc_pkg::ADDR_KIT_CTL, 8'hFF);
    rchk(uspc_pkg::ADDR_KIT_CTL, 8'h7F);
    link.wr(uspc_pkg::ADDR_KIT_CTL_CLR, 8'h7F);
    rchk(uspc_pkg::ADDR_KIT_CTL, 8'h00);
    link.wr(uspc_pkg::ADDR_KIT_CTL_SET, 8'h81);
    rchk(uspc_pkg::ADDR_KIT_CTL_SET, 8'h01);
    link.wr(uspc_pkg::ADDR_KIT_DELAY, 8'hFF);
    rchk(uspc_pkg::ADDR_KIT_DELAY, 8'h7F);
    link.wr(uspc_pkg::ADDR_KIT_IEN_SET, 8'hFF);
    rchk(uspc_pkg::ADDR_KIT_IEN, 8'h1F);
    link.wr(uspc_pkg::ADDR_KIT_IEN_CLR, 8'h1F);
    rchk(uspc_pkg::ADDR_KIT_IEN_CLR, 8'h00);
    $display("test aliases done");
  endtask : t_aliases

  task automatic t_levels;
    src = 5'h0F;
    cyc(6);
    rchk(uspc_pkg::ADDR_SRC_LEVEL, 8'h0F);
    rchk(uspc_pkg::ADDR_EVT_LATCH, 8'h0F);
    rchk(uspc_pkg::ADDR_EVT_LATCH, 8'h00);
    fall_en = 5'h00;
    src = 5'h00;
    cyc(6);
    rchk(uspc_pkg::ADDR_SRC_LEVEL, 8'h00);
    rchk(uspc_pkg::ADDR_EVT_LATCH, 8'h00);
    fall_en = 5'h1F;
    rise_en = 5'h05;
    src = 5'h0F;
    cyc(6);
    rchk(uspc_pkg::ADDR_EVT_LATCH, 8'h05);
    rise_en = 5'h1F;
    $display("test levels done");
  endtask : t_levels

  task automatic t_id_grounded;
    src = 5'h1F;
    cyc(6);
    rchk(uspc_pkg::ADDR_SRC_LEVEL, 8'h0F);
    pull_on = 1'b1;
    cyc(5);
    rchk(uspc_pkg::ADDR_SRC_LEVEL, 8'h0F);
    cyc(30);
    rchk(uspc_pkg::ADDR_SRC_LEVEL, 8'h1F);
    rchk(uspc_pkg::ADDR_EVT_LATCH, 8'h10);
    $display("test id_grounded done");
  endtask : t_id_grounded

  task automatic t_lowpower;
    src = 5'h17;
    cyc(6);
    // masked so the forced drop of bit 0 cannot refill the latch
    rise_en = 5'h00;
    fall_en = 5'h00;
    lp_on = 1'b1;
    cyc(6);
    rchk(uspc_pkg::ADDR_SRC_LEVEL, 8'h16);
    rchk(uspc_pkg::ADDR_EVT_LATCH, 8'h00);
    lp_on = 1'b0;
    rise_en = 5'h1F;
    fall_en = 5'h1F;
    cyc(6);
    rchk(uspc_pkg::ADDR_EVT_LATCH, 8'h01);
    $display("test lowpower done");
  endtask : t_lowpower

  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      susp = m[0];
      src[3] = ~src[3];
      cyc(6);
      if (m[1]) ser_on = 1'b1;
      else kit_on = 1'b1;
      cyc(3);
      rchk(uspc_pkg::ADDR_EVT_LATCH, 8'h00);
      ser_on = 1'b0;
      kit_on = 1'b0;
      cyc(2);
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_line;
    for (int i = 0; i < 4; i++) begin
      line_pin = i[1:0];
      cyc(6);
      rchk(uspc_pkg::ADDR_LINE_DEBUG, {6'h00, i[1:0]});
    end
    $display("test line done");
  endtask : t_line

  task automatic t_routes;
    link.wr(uspc_pkg::ADDR_KIT_CTL, 8'h0E);
    dp_rx = 1'b1;
    d0_tx = 1'b1;
    cyc(6);
    chk("kit_off", 8'h00, {5'h00, d1_oe, dm_oe, id_low});
    kit_on = 1'b1;
    for (int v = 0; v < 2; v++) begin
      dp_rx = v[0];
      d0_tx = ~v[0];
      cyc(6);
      chk("routes", {3'h0, 1'b1, v[0], 1'b1, ~v[0], 1'b1},
          {3'h0, d1_oe, d1_out, dm_oe, dm_out, id_low});
    end
    link.wr(uspc_pkg::ADDR_KIT_CTL_CLR, 8'h0E);
    cyc(4);
    chk("routes_off", 8'h00, {5'h00, d1_oe, dm_oe, id_low});
    $display("test routes done");
  endtask : t_routes

  task automatic t_float;
    logic [7:0] n;
    link.wr(uspc_pkg::ADDR_KIT_IEN, 8'h01);
    id_flt = 1'b1;
    pulses(n);
    chk("float_evt", 8'h01, n);
    rchk(uspc_pkg::ADDR_KIT_STS, 8'h01);
    id_flt = 1'b0;
    pulses(n);
    chk("unfloat_masked", 8'h00, n);
    rchk(uspc_pkg::ADDR_KIT_STS, 8'h00);
    link.wr(uspc_pkg::ADDR_KIT_IEN, 8'h02);
    id_flt = 1'b1;
    pulses(n);
    chk("float_masked", 8'h00, n);
    id_flt = 1'b0;
    pulses(n);
    chk("unfloat_evt", 8'h01, n);
    $display("test float done");
  endtask : t_float

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (6000) @(posedge core_clk);
    bad_count++;
    $display("unexpected watchdog expected done seen hang");
    tally_and_finish();
  end

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    src = 5'h00;
    rise_en = 5'h1F;
    fall_en = 5'h1F;
    pull_on = 1'b0;
    kit_on = 1'b0;
    ser_on = 1'b0;
    lp_on = 1'b0;
    susp = 1'b0;
    line_pin = 2'h0;
    id_flt = 1'b0;
    dp_rx = 1'b0;
    d0_tx = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    cyc(6);
    rst_n = 1'b1;
    cyc(1);
    t_reset_vals();
    t_aliases();
    t_levels();
    t_id_grounded();
    t_lowpower();
    t_modes();
    t_line();
    t_routes();
    t_float();
    tally_and_finish();
  end
endmodule : testbench
